// [hdl/ibtl_pkg.sv]
// constants for the instrument bus talker/listener port
// assumes a byte-wide bus with standard interface-message codes
package ibtl_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned FIFO_WIDTH  = 8;
  localparam int unsigned FIFO_DEPTH  = 8;
  // processor register indices
  localparam logic [1:0] RD_STATE     = 2'h0;
  localparam logic [1:0] RD_COMMAND   = 2'h1;
  localparam logic [1:0] RD_CAUSE     = 2'h2;
  localparam logic [1:0] RD_DATA      = 2'h3;
  localparam logic [1:0] WR_CONTROL   = 2'h1;
  localparam logic [1:0] WR_STATUS    = 2'h2;
  localparam logic [1:0] WR_DATA      = 2'h3;
  // control-out bits
  localparam int unsigned CTL_CLR_ADDR   = 0;
  localparam int unsigned CTL_CLR_REMOTE = 1;
  // interface messages on the data lines, bit 7 ignored
  localparam logic [6:0] MSG_GTL      = 7'h01;
  localparam logic [6:0] MSG_SDC      = 7'h04;
  localparam logic [6:0] MSG_GET      = 7'h08;
  localparam logic [6:0] MSG_LLO      = 7'h11;
  localparam logic [6:0] MSG_DCL      = 7'h14;
  localparam logic [6:0] MSG_SPE      = 7'h18;
  localparam logic [6:0] MSG_SPD      = 7'h19;
  localparam logic [6:0] MSG_UNL      = 7'h3f;
  localparam logic [1:0] GRP_LISTEN   = 2'h1;
  localparam logic [1:0] GRP_TALK     = 2'h2;
  // command-in codes: three decoded bits then the class bit
  localparam logic [3:0] CODE_LLO     = 4'h1;
  localparam logic [3:0] CODE_DCL     = 4'h9;
  localparam logic [3:0] CODE_GTL     = 4'h0;
  localparam logic [3:0] CODE_SDC     = 4'h8;
  localparam logic [3:0] CODE_GET     = 4'h6;
  // reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [3:0] RST_CODE     = 4'h0;
endpackage : ibtl_pkg

// [hdl/ibtl_port.sv]
// talker/listener port: command decode, flags, acceptor and source handshakes
// assumes processor selects are one-cycle strobes on clk; bus pins are asynchronous
// How it works
// [RULE_01] accept bytes only under attention or listen
// [RULE_02] decoder strobe one clock before accepted rises
// [RULE_03] unlisten clears the listen flag
// [RULE_04] any talk address reloads talk flag
// [RULE_05] own listen address sets listen flag
// [RULE_06] data byte sets flag, latches, interrupts
// [RULE_07] reading cause register clears interrupt
// [RULE_08] reading data-in clears flag, raises ready
// [RULE_09] command byte sets flag, latches code, interrupts
// [RULE_10] code class bit one for universal
// [RULE_11] poll enable sets, poll disable clears
// [RULE_12] two stage valid sync, then strobe
// [RULE_13] data strobe drops ready and interrupts
// [RULE_14] strobe ends, accepted rises next clock
// [RULE_15] valid gone, accepted returns low
// [RULE_16] data write clears free, valid later
// [RULE_17] accepted seen sets free next clock
// [RULE_18] valid released clock after free sets
// [RULE_19] valid waits for listener ready
// [RULE_20] writes barred in poll; drive only talking
// [RULE_21] software checks talk and free first
// [RULE_22] read/write and two bits pick registers
// [RULE_23] software writes poll status byte
// [RULE_24] reset clears flags and handshakes, sets free
`timescale 1ns/100ps
`default_nettype none

module ibtl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : ibtl_fifo

module ibtl_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // own bus address
  input  wire logic [4:0] own_address,
  // processor registers
  input  wire logic       cpu_sel,
  input  wire logic       cpu_rnw,
  input  wire logic [1:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  output logic            processor_interrupt_low,
  output logic            data_out_write_ready,
  // bus data lines
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe,
  // bus control lines
  input  wire logic       attention_asserted_low,
  input  wire logic       data_valid_low_in,
  output logic            data_valid_low_out,
  output logic            data_valid_low_oe,
  input  wire logic       data_accepted_high_in,
  output logic            data_accepted_high_out,
  input  wire logic       ready_for_data_high_in,
  output logic            ready_for_data_high_out
);
  typedef enum logic [3:0] {
    ACC_IDLE   = 4'b0001,
    ACC_SYNC   = 4'b0010,
    ACC_STROBE = 4'b0100,
    ACC_DONE   = 4'b1000
  } ibtl_acc_e;
  typedef enum logic [3:0] {
    SRC_IDLE = 4'b0001,
    SRC_ARM  = 4'b0010,
    SRC_DAV  = 4'b0100,
    SRC_REL  = 4'b1000
  } ibtl_src_e;

  // pin synchronisers, first stage read only by second
  logic [7:0] data_m;
  logic [7:0] data_s;
  logic [3:0] ctl_m;
  logic [3:0] ctl_s;
  logic       atn;
  logic       dav_in;
  logic       dac_in;
  logic       rfd_in;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_m <= ibtl_pkg::RST_BYTE;
      data_s <= ibtl_pkg::RST_BYTE;
      ctl_m  <= 4'hf;
      ctl_s  <= 4'hf;
    end else begin
      data_m <= bus_data_in;
      data_s <= data_m;
      ctl_m  <= {attention_asserted_low, data_valid_low_in,
                 ~data_accepted_high_in, ~ready_for_data_high_in};
      ctl_s  <= ctl_m;
    end
  end

  assign atn    = ~ctl_s[3];
  assign dav_in = ~ctl_s[2];
  assign dac_in = ~ctl_s[1];
  assign rfd_in = ~ctl_s[0];

  // flags and registers
  logic       listen;
  logic       talk;
  logic       spoll;
  logic       remote;
  logic       data_flag;
  logic       cmd_flag;
  logic       irq_flag;
  logic       free;
  logic [7:0] data_in_reg;
  logic [3:0] cmd_code;
  logic [7:0] status_reg;
  ibtl_acc_e  acc_state;
  ibtl_src_e  src_state;

  // register decode
  logic rd_state;
  logic rd_cmd;
  logic rd_cause;
  logic rd_data;
  logic wr_ctl;
  logic wr_status;
  logic wr_data;

  always_comb begin
    rd_state  = 1'b0;
    rd_cmd    = 1'b0;
    rd_cause  = 1'b0;
    rd_data   = 1'b0;
    wr_ctl    = 1'b0;
    wr_status = 1'b0;
    wr_data   = 1'b0;
    if (cpu_sel && cpu_rnw && cpu_addr == ibtl_pkg::RD_STATE) begin // [RULE_22]
      rd_state = 1'b1;
    end else if (cpu_sel && cpu_rnw && cpu_addr == ibtl_pkg::RD_COMMAND) begin
      rd_cmd = 1'b1;
    end else if (cpu_sel && cpu_rnw && cpu_addr == ibtl_pkg::RD_CAUSE) begin
      rd_cause = 1'b1;
    end else if (cpu_sel && cpu_rnw && cpu_addr == ibtl_pkg::RD_DATA) begin
      rd_data = 1'b1;
    end else if (cpu_sel && !cpu_rnw && cpu_addr == ibtl_pkg::WR_CONTROL) begin
      wr_ctl = 1'b1;
    end else if (cpu_sel && !cpu_rnw && cpu_addr == ibtl_pkg::WR_STATUS) begin
      wr_status = 1'b1;
    end else if (cpu_sel && !cpu_rnw && cpu_addr == ibtl_pkg::WR_DATA) begin
      wr_data = 1'b1;
    end
  end

  // combinational byte decode, always enabled
  logic [6:0] msg;
  logic       is_listen_grp;
  logic       is_talk_grp;
  logic       own_match;
  logic       universal;
  logic       addressed;
  logic [3:0] decoded_code;
  logic       strobe;
  logic       strobe_cmd;
  logic       strobe_data;

  assign msg           = data_s[6:0];
  assign own_match     = msg[4:0] == own_address;
  assign is_listen_grp = atn && msg[6:5] == ibtl_pkg::GRP_LISTEN;
  assign is_talk_grp   = atn && msg[6:5] == ibtl_pkg::GRP_TALK;
  assign universal     = atn && (msg == ibtl_pkg::MSG_LLO || msg == ibtl_pkg::MSG_DCL);
  assign addressed     = atn && listen && (msg == ibtl_pkg::MSG_GTL ||
                         msg == ibtl_pkg::MSG_SDC || msg == ibtl_pkg::MSG_GET);

  always_comb begin
    decoded_code = ibtl_pkg::CODE_GTL;
    case (msg) // [RULE_10]
      ibtl_pkg::MSG_LLO: decoded_code = ibtl_pkg::CODE_LLO;
      ibtl_pkg::MSG_DCL: decoded_code = ibtl_pkg::CODE_DCL;
      ibtl_pkg::MSG_SDC: decoded_code = ibtl_pkg::CODE_SDC;
      ibtl_pkg::MSG_GET: decoded_code = ibtl_pkg::CODE_GET;
      default:           decoded_code = ibtl_pkg::CODE_GTL;
    endcase
  end

  // sequenced decode only during the strobe
  assign strobe      = acc_state == ACC_STROBE; // [RULE_02]
  assign strobe_cmd  = strobe && (universal || addressed);
  assign strobe_data = strobe && !atn && listen;

  // acceptor handshake
  logic acc_en;
  assign acc_en = atn || listen; // [RULE_01]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_state              <= ACC_IDLE; // [RULE_24]
      data_accepted_high_out <= 1'b0;
    end else begin
      case (acc_state)
        ACC_IDLE: begin
          if (acc_en && dav_in && (atn || !data_flag)) begin // [RULE_12]
            acc_state <= ACC_SYNC;
          end
        end
        ACC_SYNC: begin
          acc_state <= ACC_STROBE; // [RULE_12]
        end
        ACC_STROBE: begin
          acc_state              <= ACC_DONE; // [RULE_14]
          data_accepted_high_out <= 1'b1;
        end
        ACC_DONE: begin
          if (!dav_in) begin
            acc_state              <= ACC_IDLE; // [RULE_15]
            data_accepted_high_out <= 1'b0;
          end
        end
        default: begin
          acc_state              <= ACC_IDLE;
          data_accepted_high_out <= 1'b0;
        end
      endcase
    end
  end

  // address and poll flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      listen <= 1'b0;
      talk   <= 1'b0;
      spoll  <= 1'b0;
      remote <= 1'b0;
    end else begin
      if (strobe && atn && msg == ibtl_pkg::MSG_UNL) begin
        listen <= 1'b0; // [RULE_03]
      end else if (strobe && is_listen_grp && own_match) begin
        listen <= 1'b1; // [RULE_05]
      end else if (wr_ctl && cpu_wdata[ibtl_pkg::CTL_CLR_ADDR]) begin
        listen <= 1'b0;
      end
      if (strobe && is_talk_grp) begin
        talk <= own_match; // [RULE_04]
      end else if (wr_ctl && cpu_wdata[ibtl_pkg::CTL_CLR_ADDR]) begin
        talk <= 1'b0;
      end
      if (strobe && atn && msg == ibtl_pkg::MSG_SPE) begin
        spoll <= 1'b1; // [RULE_11]
      end else if (strobe && atn && msg == ibtl_pkg::MSG_SPD) begin
        spoll <= 1'b0; // [RULE_11]
      end else if (wr_ctl && cpu_wdata[ibtl_pkg::CTL_CLR_ADDR]) begin
        spoll <= 1'b0;
      end
      if (strobe && is_listen_grp && own_match) begin
        remote <= 1'b1;
      end else if (wr_ctl && cpu_wdata[ibtl_pkg::CTL_CLR_REMOTE]) begin
        remote <= 1'b0;
      end
    end
  end

  // data and command latches; hardware set wins over a read clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_flag   <= 1'b0;
      cmd_flag    <= 1'b0;
      irq_flag    <= 1'b0;
      data_in_reg <= ibtl_pkg::RST_BYTE;
      cmd_code    <= ibtl_pkg::RST_CODE;
    end else begin
      if (strobe_data) begin
        data_flag   <= 1'b1; // [RULE_06] [RULE_13]
        data_in_reg <= data_s;
      end else if (rd_data) begin
        data_flag <= 1'b0; // [RULE_08]
      end
      if (strobe_cmd) begin
        cmd_flag <= 1'b1; // [RULE_09]
        cmd_code <= decoded_code;
      end else if (rd_cmd) begin
        cmd_flag <= 1'b0;
      end
      if (strobe_data || strobe_cmd) begin
        irq_flag <= 1'b1; // [RULE_06] [RULE_09]
      end else if (rd_cause) begin
        irq_flag <= 1'b0; // [RULE_07]
      end
    end
  end

  // processor read port and bus-facing outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_rdata               <= ibtl_pkg::RST_BYTE;
      status_reg              <= ibtl_pkg::RST_BYTE;
      processor_interrupt_low <= 1'b1;
      ready_for_data_high_out <= 1'b0;
    end else begin
      if (rd_state) begin
        cpu_rdata <= {4'h0, remote, spoll, talk, listen};
      end else if (rd_cmd) begin
        cpu_rdata <= {4'h0, cmd_code};
      end else if (rd_cause) begin
        cpu_rdata <= {5'h00, free, data_flag, cmd_flag};
      end else if (rd_data) begin
        cpu_rdata <= data_in_reg;
      end
      if (wr_status) begin
        status_reg <= cpu_wdata;
      end
      processor_interrupt_low <= ~((strobe_data || strobe_cmd) || (irq_flag && !rd_cause));
      ready_for_data_high_out <= listen && !strobe_data && (rd_data || !data_flag); // [RULE_08] [RULE_13]
    end
  end

  // data-out path through the fifo
  logic       talk_en;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [7:0] fifo_out_data;
  logic       out_push;

  assign talk_en  = talk && !atn; // [RULE_20]
  assign out_push = wr_data && !spoll; // [RULE_20]
  assign fifo_pop = src_state == SRC_REL;

  ibtl_fifo #(
    .WIDTH (ibtl_pkg::FIFO_WIDTH),
    .DEPTH (ibtl_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (out_push),
    .in_ready  (fifo_in_ready),
    .in_data   (cpu_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // source handshake
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_state          <= SRC_IDLE; // [RULE_24]
      free               <= 1'b1;
      data_valid_low_out <= 1'b1;
    end else begin
      case (src_state)
        SRC_IDLE: begin
          if (talk_en && fifo_out_valid) begin
            src_state <= SRC_ARM;
          end
        end
        SRC_ARM: begin
          if (!talk_en) begin
            src_state <= SRC_IDLE;
          end else if (rfd_in && !dac_in) begin
            src_state          <= SRC_DAV; // [RULE_16] [RULE_19]
            data_valid_low_out <= 1'b0;
          end
        end
        SRC_DAV: begin
          if (dac_in) begin
            src_state <= SRC_REL; // [RULE_17]
          end
        end
        SRC_REL: begin
          src_state          <= SRC_IDLE; // [RULE_18]
          data_valid_low_out <= 1'b1;
        end
        default: begin
          src_state          <= SRC_IDLE;
          data_valid_low_out <= 1'b1;
        end
      endcase
      if (src_state == SRC_DAV && dac_in) begin
        free <= 1'b1; // [RULE_17]
      end else if (out_push && fifo_in_ready) begin
        free <= 1'b0; // [RULE_16]
      end
    end
  end

  // bus drivers only while talking with attention released
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_data_out         <= ibtl_pkg::RST_BYTE;
      bus_data_oe          <= 1'b0;
      data_valid_low_oe    <= 1'b0;
      data_out_write_ready <= 1'b0;
    end else begin
      bus_data_out         <= spoll ? status_reg : fifo_out_data;
      bus_data_oe          <= talk_en; // [RULE_20]
      data_valid_low_oe    <= talk_en && !spoll;
      data_out_write_ready <= fifo_in_ready && !spoll;
    end
  end
endmodule : ibtl_port

`default_nettype wire

// [sim/ibtl_port_assertions.sv]
// checker for the talker/listener port: bus and processor pin relations
// assumes it is bound into every ibtl_port and sees only that module's pins
`timescale 1ns/100ps
`default_nettype none

module ibtl_port_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // processor side
  input wire logic       cpu_sel,
  input wire logic       cpu_rnw,
  input wire logic [1:0] cpu_addr,
  input wire logic       processor_interrupt_low,
  input wire logic       data_out_write_ready,
  // bus side
  input wire logic       bus_data_oe,
  input wire logic       attention_asserted_low,
  input wire logic       data_valid_low_in,
  input wire logic       data_valid_low_out,
  input wire logic       data_valid_low_oe,
  input wire logic       data_accepted_high_in,
  input wire logic       data_accepted_high_out,
  input wire logic       ready_for_data_high_in,
  input wire logic       ready_for_data_high_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_reset_idle;
    $fell(sys_rst) |-> processor_interrupt_low && data_valid_low_out
      && !data_accepted_high_out && !bus_data_oe && !data_valid_low_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");

  property p_accept_late;
    $rose(data_accepted_high_out) |-> !$past(data_valid_low_in, 3);
  endproperty
  a_accept_late: assert property (p_accept_late)
    else $error("accepted raised before valid was synchronised");

  property p_accept_drop;
    $rose(data_valid_low_in) |-> ##[1:5] !data_accepted_high_out;
  endproperty
  a_accept_drop: assert property (p_accept_drop)
    else $error("accepted held after valid went away");

  property p_data_ready_low;
    $rose(data_accepted_high_out) && attention_asserted_low |-> !ready_for_data_high_out;
  endproperty
  a_data_ready_low: assert property (p_data_ready_low)
    else $error("ready still high while data byte taken");

  property p_data_irq;
    $rose(data_accepted_high_out) && attention_asserted_low |-> !processor_interrupt_low;
  endproperty
  a_data_irq: assert property (p_data_irq)
    else $error("no interrupt with data byte");

  property p_cause_clears;
    cpu_sel && cpu_rnw && cpu_addr == ibtl_pkg::RD_CAUSE
      |=> processor_interrupt_low || $rose(data_accepted_high_out);
  endproperty
  a_cause_clears: assert property (p_cause_clears)
    else $error("interrupt kept after cause read");

  property p_data_read_ready;
    cpu_sel && cpu_rnw && cpu_addr == ibtl_pkg::RD_DATA |=> ready_for_data_high_out;
  endproperty
  a_data_read_ready: assert property (p_data_read_ready)
    else $error("ready not raised after data read");

  property p_valid_release;
    $rose(data_valid_low_out) |-> $past(data_accepted_high_in, 3);
  endproperty
  a_valid_release: assert property (p_valid_release)
    else $error("valid released without accepted");

  property p_valid_waits;
    $fell(data_valid_low_out) |-> $past(ready_for_data_high_in, 3);
  endproperty
  a_valid_waits: assert property (p_valid_waits)
    else $error("valid asserted without listener ready");

  property p_no_drive_atn;
    !attention_asserted_low [*4] |-> !data_valid_low_oe && !bus_data_oe;
  endproperty
  a_no_drive_atn: assert property (p_no_drive_atn)
    else $error("bus driven under attention");

  c_data_accept: cover property ($rose(data_accepted_high_out) && attention_asserted_low);
  c_talk_valid: cover property ($fell(data_valid_low_out));
  c_fifo_full: cover property ($fell(data_out_write_ready));
endmodule : ibtl_port_checker

bind ibtl_port ibtl_port_checker u_chk (
  .clk, .sys_rst, .cpu_sel, .cpu_rnw, .cpu_addr, .processor_interrupt_low,
  .data_out_write_ready, .bus_data_oe, .attention_asserted_low, .data_valid_low_in,
  .data_valid_low_out, .data_valid_low_oe, .data_accepted_high_in, .data_accepted_high_out,
  .ready_for_data_high_in, .ready_for_data_high_out
);

`default_nettype wire

// [sim/ibtl_bus_model.sv]
// far side of the bus: controller/talker and one listener
// assumes lines change at the falling clock edge; released lines float high
`timescale 1ns/100ps
`default_nettype none

module ibtl_bus_model (
  // clock
  input  wire logic       clk,
  // lines driven by the model
  output logic            atn_n,
  output logic            dav_n,
  output logic      [7:0] data,
  output logic            acc,
  output logic            rfd,
  // lines from the device
  input  wire logic       dev_dav_n,
  input  wire logic [7:0] dev_data,
  input  wire logic       dev_acc
);
  logic       stall;
  logic [7:0] got[$];

  initial begin
    atn_n = 1'b1;
    dav_n = 1'b1;
    data  = 8'hff;
    acc   = 1'b0;
    rfd   = 1'b0;
    stall = 1'b0;
  end

  // listener: stall holds ready low to slow the talker
  always @(negedge clk) begin
    if (!dev_dav_n && !acc) begin
      got.push_back(dev_data);
      acc <= 1'b1;
      rfd <= 1'b0;
    end else if (dev_dav_n && acc) begin
      acc <= 1'b0;
    end else if (dev_dav_n) begin
      rfd <= !stall;
    end
  end

  task automatic send(input logic [7:0] b, input logic atn, output logic ok);
    int n;
    @(negedge clk);
    atn_n = ~atn;
    data  = b;
    @(negedge clk);
    dav_n = 1'b0;
    n = 0;
    while (dev_acc !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    ok    = dev_acc;
    dav_n = 1'b1;
    data  = 8'hff;
    n = 0;
    while (dev_acc !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    // an accepted line that never drops also counts as a failed transfer
    if (dev_acc !== 1'b0) ok = 1'b0;
  endtask : send

  task automatic rel;
    @(negedge clk);
    atn_n = 1'b1;
  endtask : rel
endmodule : ibtl_bus_model

`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the talker/listener port
// assumes the bus model sits on the far side; inputs change at falling edges
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam logic [6:0] MSGS [5] = '{ibtl_pkg::MSG_LLO, ibtl_pkg::MSG_DCL,
    ibtl_pkg::MSG_GTL, ibtl_pkg::MSG_SDC, ibtl_pkg::MSG_GET};
  localparam logic [3:0] CODES [5] = '{ibtl_pkg::CODE_LLO, ibtl_pkg::CODE_DCL,
    ibtl_pkg::CODE_GTL, ibtl_pkg::CODE_SDC, ibtl_pkg::CODE_GET};
  logic       clk, sys_rst, cpu_sel, cpu_rnw, irq_n, wr_rdy, data_oe;
  logic       dav_out, dav_oe, acc_out, rfd_out, bm_atn, bm_dav, bm_acc, bm_rfd;
  logic       dev_dav, dav_w, listen, talk, spoll, remote;
  logic [1:0] cpu_addr;
  logic [4:0] own;
  logic [7:0] cpu_wdata, cpu_rdata, bus_data_out, bm_data, data_w;
  logic [7:0] exp_q[$];
  int         num_errors, cmp_count, seed;

  assign dev_dav = dav_oe ? dav_out : 1'b1;
  assign dav_w   = bm_dav & dev_dav;
  assign data_w  = bm_data & (data_oe ? bus_data_out : 8'hff);

  ibtl_port uut (
    .clk(clk), .sys_rst(sys_rst), .own_address(own), .cpu_sel(cpu_sel),
    .cpu_rnw(cpu_rnw), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .processor_interrupt_low(irq_n), .data_out_write_ready(wr_rdy),
    .bus_data_in(data_w), .bus_data_out(bus_data_out), .bus_data_oe(data_oe),
    .attention_asserted_low(bm_atn), .data_valid_low_in(dav_w),
    .data_valid_low_out(dav_out), .data_valid_low_oe(dav_oe),
    .data_accepted_high_in(bm_acc), .data_accepted_high_out(acc_out),
    .ready_for_data_high_in(bm_rfd), .ready_for_data_high_out(rfd_out)
  );

  ibtl_bus_model bm (
    .clk(clk), .atn_n(bm_atn), .dav_n(bm_dav), .data(bm_data), .acc(bm_acc),
    .rfd(bm_rfd), .dev_dav_n(dev_dav), .dev_data(bus_data_out), .dev_acc(acc_out)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cpu(input logic rnw, input logic [1:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    cpu_sel   = 1'b1;
    cpu_rnw   = rnw;
    cpu_addr  = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_sel = 1'b0;
    @(negedge clk);
    q = cpu_rdata;
  endtask : cpu

  task automatic chk_state;
    logic [7:0] q;
    cpu(1'b1, ibtl_pkg::RD_STATE, 8'h00, q);
    chk({4'h0, q[3:0]}, {4'h0, remote, spoll, talk, listen}, "state");
  endtask : chk_state

  initial begin
    #1_000_000;
    num_errors++;
    report_and_stop();
  end

  initial begin : main
    logic [7:0] q, d;
    logic       ok;
    int         n;
    sys_rst = 1'b1;
    cpu_sel = 1'b0;
    cpu_rnw = 1'b1;
    cpu_addr = 2'h0;
    cpu_wdata = 8'h00;
    own = 5'h0b;
    {listen, talk, spoll, remote} = 4'h0;
    seed = 66;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk({7'h0, irq_n}, 8'h01, "irq idle");
    chk({6'h0, dav_out, acc_out}, 8'h02, "handshake idle");
    chk_state();
    bm.send(8'($random(seed)), 1'b0, ok);
    chk({7'h0, ok}, 8'h00, "unaddressed accept");
    bm.send({3'h1, own}, 1'b1, ok);
    {listen, remote} = 2'h3;
    chk({7'h0, ok}, 8'h01, "address accept");
    chk_state();
    bm.rel();
    d = 8'($random(seed));
    bm.send(d, 1'b0, ok);
    chk({7'h0, irq_n}, 8'h00, "data irq");
    cpu(1'b1, ibtl_pkg::RD_CAUSE, 8'h00, q);
    chk({5'h0, q[2:0]}, 8'h06, "cause data");
    chk({7'h0, irq_n}, 8'h01, "irq released");
    cpu(1'b1, ibtl_pkg::RD_DATA, 8'h00, q);
    chk(q, d, "data in");
    chk({7'h0, rfd_out}, 8'h01, "ready after read");
    for (int i = 0; i < 5; i++) begin
      bm.send({1'b0, MSGS[i]}, 1'b1, ok);
      chk({7'h0, irq_n}, 8'h00, "command irq");
      cpu(1'b1, ibtl_pkg::RD_CAUSE, 8'h00, q);
      chk({5'h0, q[2:0]}, 8'h05, "cause command");
      cpu(1'b1, ibtl_pkg::RD_COMMAND, 8'h00, q);
      chk({4'h0, q[3:0]}, {4'h0, CODES[i]}, "command code");
    end
    bm.send({1'b0, ibtl_pkg::MSG_SPE}, 1'b1, ok);
    spoll = 1'b1;
    chk_state();
    chk({7'h0, wr_rdy}, 8'h00, "write in poll");
    bm.send({1'b0, ibtl_pkg::MSG_SPD}, 1'b1, ok);
    spoll = 1'b0;
    chk_state();
    bm.send({1'b0, ibtl_pkg::MSG_UNL}, 1'b1, ok);
    listen = 1'b0;
    chk_state();
    bm.send({3'h2, own}, 1'b1, ok);
    talk = 1'b1;
    chk_state();
    bm.send({3'h2, own ^ 5'h01}, 1'b1, ok);
    talk = 1'b0;
    chk_state();
    bm.send({3'h2, own}, 1'b1, ok);
    talk = 1'b1;
    bm.stall = 1'b1;
    bm.rel();
    for (int i = 0; i < 8; i++) begin
      chk({7'h0, wr_rdy}, 8'h01, "write ready");
      d = 8'($random(seed));
      exp_q.push_back(d);
      cpu(1'b0, ibtl_pkg::WR_DATA, d, q);
    end
    chk({7'h0, wr_rdy}, 8'h00, "buffer full");
    chk({7'h0, dav_out}, 8'h01, "valid held off");
    bm.stall = 1'b0;
    n = 0;
    while (bm.got.size() < 8 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(8'(bm.got.size()), 8'h08, "bytes sent");
    foreach (exp_q[i]) chk(bm.got[i], exp_q[i], "byte out");
    // serial poll while talking: status byte on the lines, no valid drive
    cpu(1'b0, ibtl_pkg::WR_STATUS, 8'h50, q);
    bm.send({1'b0, ibtl_pkg::MSG_SPE}, 1'b1, ok);
    bm.rel();
    repeat (4) @(negedge clk);
    chk(bus_data_out, 8'h50, "poll status byte");
    chk({6'h0, data_oe, dav_oe}, 8'h02, "poll drive");
    cpu(1'b0, ibtl_pkg::WR_CONTROL, 8'h01, q);
    {talk, spoll} = 2'h0;
    chk_state();
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    {listen, talk, spoll, remote} = 4'h0;
    chk_state();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
